// ===== logic/scc_pkg.sv
package scc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // supply rise window and automatic delay in the dual-threshold mode
    localparam int FAST_RISE_NS = 1930000;
    localparam int POC_DELAY_NS = 5390000;
    // regulator wait in the single-threshold mode
    localparam int REG_WAIT_NS = 100000;
    // least cpu clock gap after the gain bit goes high
    localparam int GAIN_HOLD_NS = 4060;
    localparam int FAST_RISE_CYC = FAST_RISE_NS / CLK_PERIOD_NS;
    localparam int POC_DELAY_CYC = POC_DELAY_NS / CLK_PERIOD_NS;
    localparam int REG_WAIT_CYC =
        (REG_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAIN_HOLD_CYC =
        (GAIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PROC_CYC = 16;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_OSC_PIN_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MAIN_OSC_CONTROL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STAB_STATUS_COUNTER = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STAB_TIME_SELECTOR = 4'h3;

    localparam int GAIN_BIT = 0;
    localparam int PIN_OSC_EN_BIT = 6;
    localparam int EXT_SEL_BIT = 7;
    localparam int MAIN_STOP_BIT = 7;
    localparam int SEL_W = 3;
    localparam int STATUS_W = 5;
    localparam logic [SEL_W-1:0] STAB_SEL_RST = 3'h5;
    localparam logic MAIN_STOP_RST = 1'b1;
    localparam int STAB_CNT_W = 17;

    typedef enum logic [2:0] {
        POC_OFF, POC_REG_WAIT, POC_DUAL_WAIT, POC_DELAY,
        POC_RESET_PROC, POC_RUN
    } scc_poc_e;

    typedef enum logic [1:0] {PIN_PORT, PIN_XTAL, PIN_EXTCLK} scc_pin_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } scc_req_s;

    // crystal wait in crystal periods; prohibited codes take the longest
    function automatic logic [STAB_CNT_W-1:0] stab_limit(
        input logic [SEL_W-1:0] sel);
        case (sel)
            3'h1: stab_limit = 17'h00800;
            3'h2: stab_limit = 17'h02000;
            3'h3: stab_limit = 17'h04000;
            3'h4: stab_limit = 17'h08000;
            default: stab_limit = 17'h10000;
        endcase
    endfunction : stab_limit

    // one bit per wait step reached, lowest step in bit 0
    function automatic logic [STATUS_W-1:0] stab_status(
        input logic [STAB_CNT_W-1:0] cnt);
        stab_status = {cnt >= 17'h10000, cnt >= 17'h08000,
            cnt >= 17'h04000, cnt >= 17'h02000, cnt >= 17'h00800};
    endfunction : stab_status
endpackage : scc_pkg

// ===== logic/scc_clock_ctrl.sv
// Functional notes
// - power-on clear holds the cpu in reset until release
// - above low threshold, release reset and start internal oscillator
// - cpu always starts on the internal oscillator, never on crystal
// - single-threshold mode: regulator wait, reset processing, then cpu
// - option bit picks single (0) or dual (1) threshold mode
// - dual mode: fast rise to high threshold inserts a delay
// - on internal clock poll status; on crystal selector sets stop wait
// - external clock input needs no stabilisation wait
// - unused clocks can be stopped; stop halts both high clocks
// - high-speed clock pins come up as port pins after reset
// - gain bit 0 low gain, 1 high gain above mid limit
// - gain bit accepts one change per reset release
// - writing gain bit to 1 gates the cpu clock briefly
// - external select 0 with pin enable 1 gives crystal mode
// - clearing the main stop bit starts the crystal
// - cpu runs on internal clock while crystal stabilises
// - selector resets to 05h and picks 2^11..2^16 periods
// - status counter stops at the time the selector picks
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module scc_clock_ctrl #(
    parameter int FAST_RISE_CYC = scc_pkg::FAST_RISE_CYC,
    parameter int POC_DELAY_CYC = scc_pkg::POC_DELAY_CYC,
    parameter int REG_WAIT_CYC = scc_pkg::REG_WAIT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // supply monitor and option strap
    input wire logic poc_low_ok_i,
    input wire logic poc_high_ok_i,
    input wire logic poc_threshold_option_i,
    // cpu side
    input wire logic stop_instr_i,
    input wire logic stop_release_i,
    input wire logic cpu_on_hs_clock_i,
    // sampled crystal or external clock pin
    input wire logic main_crystal_clock_i,
    // register port
    input wire scc_pkg::scc_req_s reg_req_i,
    output logic [scc_pkg::DATA_W-1:0] rd_data_o,
    // clock and pin controls
    output logic cpu_rst_n_o,
    output logic cpu_clk_en_o,
    output logic int_osc_run_o,
    output logic xtal_amp_en_o,
    output logic osc_high_gain_o,
    output scc_pkg::scc_pin_e pin_mode_o
);
    localparam int PCNT_W = $clog2(POC_DELAY_CYC + 1) + 1;
    localparam int GAIN_HOLD_CYC = scc_pkg::GAIN_HOLD_CYC;
    localparam int RESET_PROC_CYC = scc_pkg::RESET_PROC_CYC;
    localparam int GCNT_W = $clog2(GAIN_HOLD_CYC + 1);

    scc_pkg::scc_poc_e poc_q;
    logic [PCNT_W-1:0] poc_cnt_q;
    logic sys_rst;
    logic gain_q, gain_locked_q, pin_en_q, ext_sel_q, main_stop_q;
    logic [scc_pkg::SEL_W-1:0] sel_q;
    logic [GCNT_W-1:0] gain_hold_q;
    logic stop_q, stop_wait_q;
    logic [scc_pkg::STAB_CNT_W-1:0] stab_cnt_q, limit, lim_nxt;
    logic xtal_pin_q, xtal_on, xtal_on_q, stab_done;
    scc_pkg::scc_pin_e pin_mode;
    logic wr_pin, wr_main, wr_sel;

    assign sys_rst = !rstn_i || (poc_q != scc_pkg::POC_RUN);
    assign wr_pin = reg_req_i.wr &&
        reg_req_i.addr == scc_pkg::ADDR_OSC_PIN_CONTROL;
    assign wr_main = reg_req_i.wr &&
        reg_req_i.addr == scc_pkg::ADDR_MAIN_OSC_CONTROL;
    assign wr_sel = reg_req_i.wr &&
        reg_req_i.addr == scc_pkg::ADDR_STAB_TIME_SELECTOR;
    assign limit = scc_pkg::stab_limit(sel_q);
    assign stab_done = stab_cnt_q >= limit;
    // a shorter selected time clips the count on the same edge
    assign lim_nxt = wr_sel ?
        scc_pkg::stab_limit(reg_req_i.wdata[scc_pkg::SEL_W-1:0]) : limit;

    always_comb begin
        if (!pin_en_q) begin
            pin_mode = scc_pkg::PIN_PORT;
        end else if (ext_sel_q) begin
            pin_mode = scc_pkg::PIN_EXTCLK;
        end else begin
            pin_mode = scc_pkg::PIN_XTAL;
        end
    end

    // crystal or external input runs only when software asks for it
    assign xtal_on = pin_mode != scc_pkg::PIN_PORT && !main_stop_q &&
        !stop_q;

    // power-on clear sequencing; falling supply always drops back to off
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !poc_low_ok_i) begin
            poc_q <= scc_pkg::POC_OFF;
            poc_cnt_q <= '0;
        end else begin
            poc_cnt_q <= poc_cnt_q + 1'b1;
            case (poc_q)
                scc_pkg::POC_OFF: begin
                    poc_cnt_q <= '0;
                    poc_q <= poc_threshold_option_i ?
                        scc_pkg::POC_DUAL_WAIT : scc_pkg::POC_REG_WAIT;
                end
                scc_pkg::POC_REG_WAIT: begin
                    if (poc_cnt_q == PCNT_W'(REG_WAIT_CYC - 1)) begin
                        poc_q <= scc_pkg::POC_RESET_PROC;
                        poc_cnt_q <= '0;
                    end
                end
                scc_pkg::POC_DUAL_WAIT: begin
                    if (poc_high_ok_i) begin
                        if (poc_cnt_q < PCNT_W'(FAST_RISE_CYC)) begin
                            poc_q <= scc_pkg::POC_DELAY;
                        end else begin
                            poc_q <= scc_pkg::POC_RESET_PROC;
                            poc_cnt_q <= '0;
                        end
                    end
                end
                scc_pkg::POC_DELAY: begin
                    // delay runs out at the longest time after low threshold
                    if (poc_cnt_q >= PCNT_W'(POC_DELAY_CYC - 1)) begin
                        poc_q <= scc_pkg::POC_RESET_PROC;
                        poc_cnt_q <= '0;
                    end
                end
                scc_pkg::POC_RESET_PROC: begin
                    if (poc_cnt_q == PCNT_W'(RESET_PROC_CYC - 1)) begin
                        poc_q <= scc_pkg::POC_RUN;
                    end
                end
                scc_pkg::POC_RUN: begin
                    poc_cnt_q <= poc_cnt_q;
                end
                default: begin
                    poc_q <= scc_pkg::POC_OFF;
                end
            endcase
        end
    end

    // pin control and gain; gain takes one change per release
    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            gain_q <= 1'b0;
            gain_locked_q <= 1'b0;
            pin_en_q <= 1'b0;
            ext_sel_q <= 1'b0;
        end else if (wr_pin) begin
            pin_en_q <= reg_req_i.wdata[scc_pkg::PIN_OSC_EN_BIT];
            ext_sel_q <= reg_req_i.wdata[scc_pkg::EXT_SEL_BIT];
            if (!gain_locked_q &&
                reg_req_i.wdata[scc_pkg::GAIN_BIT] != gain_q) begin
                gain_q <= reg_req_i.wdata[scc_pkg::GAIN_BIT];
                gain_locked_q <= 1'b1;
            end
        end
    end

    // cpu clock gap after the gain goes high
    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            gain_hold_q <= '0;
        end else if (wr_pin && !gain_locked_q && !gain_q &&
            reg_req_i.wdata[scc_pkg::GAIN_BIT]) begin
            gain_hold_q <= GCNT_W'(GAIN_HOLD_CYC);
        end else if (gain_hold_q != '0) begin
            gain_hold_q <= gain_hold_q - 1'b1;
        end
    end

    // a clock feeding the cpu cannot be stopped here
    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            main_stop_q <= scc_pkg::MAIN_STOP_RST;
        end else if (wr_main) begin
            if (!reg_req_i.wdata[scc_pkg::MAIN_STOP_BIT] ||
                !cpu_on_hs_clock_i) begin
                main_stop_q <= reg_req_i.wdata[scc_pkg::MAIN_STOP_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            sel_q <= scc_pkg::STAB_SEL_RST;
        end else if (wr_sel) begin
            sel_q <= reg_req_i.wdata[scc_pkg::SEL_W-1:0];
        end
    end

    // stop mode and the crystal wait after its release
    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            stop_q <= 1'b0;
            stop_wait_q <= 1'b0;
        end else if (stop_instr_i && !stop_q) begin
            stop_q <= 1'b1;
        end else if (stop_q && stop_release_i) begin
            stop_q <= 1'b0;
            stop_wait_q <= cpu_on_hs_clock_i &&
                pin_mode == scc_pkg::PIN_XTAL && !main_stop_q;
        end else if (stop_wait_q && stab_done) begin
            stop_wait_q <= 1'b0;
        end
    end

    // stabilisation counter counts crystal edges up to the selected time
    always_ff @(posedge clk_i) begin
        if (sys_rst) begin
            xtal_pin_q <= 1'b0;
            xtal_on_q <= 1'b0;
            stab_cnt_q <= '0;
        end else begin
            xtal_pin_q <= main_crystal_clock_i;
            xtal_on_q <= xtal_on;
            if (!xtal_on || !xtal_on_q) begin
                stab_cnt_q <= '0;
            end else if (pin_mode == scc_pkg::PIN_EXTCLK) begin
                stab_cnt_q <= lim_nxt;
            end else if (stab_cnt_q < lim_nxt) begin
                if (main_crystal_clock_i && !xtal_pin_q) begin
                    stab_cnt_q <= stab_cnt_q + 1'b1;
                end
            end else begin
                stab_cnt_q <= lim_nxt;
            end
        end
    end

    // registered outputs; cpu always starts on the internal oscillator
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cpu_rst_n_o <= 1'b0;
            cpu_clk_en_o <= 1'b0;
            int_osc_run_o <= 1'b0;
            xtal_amp_en_o <= 1'b0;
            osc_high_gain_o <= 1'b0;
            pin_mode_o <= scc_pkg::PIN_PORT;
        end else begin
            cpu_rst_n_o <= !sys_rst;
            int_osc_run_o <= !sys_rst && !stop_q;
            cpu_clk_en_o <= !sys_rst && !stop_q && gain_hold_q == '0 &&
                !stop_wait_q;
            xtal_amp_en_o <= xtal_on && pin_mode == scc_pkg::PIN_XTAL;
            osc_high_gain_o <= gain_q;
            pin_mode_o <= pin_mode;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i || !reg_req_i.rd) begin
            rd_data_o <= '0;
        end else begin
            case (reg_req_i.addr)
                scc_pkg::ADDR_OSC_PIN_CONTROL:
                    rd_data_o <= {ext_sel_q, pin_en_q, 5'h00, gain_q};
                scc_pkg::ADDR_MAIN_OSC_CONTROL:
                    rd_data_o <= {main_stop_q, 7'h00};
                scc_pkg::ADDR_STAB_STATUS_COUNTER:
                    rd_data_o <= {3'h0, scc_pkg::stab_status(stab_cnt_q)};
                scc_pkg::ADDR_STAB_TIME_SELECTOR:
                    rd_data_o <= {5'h00, sel_q};
                default:
                    rd_data_o <= '0;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    reset_hold_a: assert property (
        !poc_low_ok_i |=> ##1 !cpu_rst_n_o && !cpu_clk_en_o)
        else $error("cpu left reset while supply low");
    poc_release_a: assert property (
        poc_q == scc_pkg::POC_RESET_PROC && poc_low_ok_i &&
        poc_cnt_q == PCNT_W'(RESET_PROC_CYC - 1)
        |=> ##1 cpu_rst_n_o && int_osc_run_o)
        else $error("reset release did not start internal oscillator");
    start_on_int_a: assert property (
        $rose(cpu_rst_n_o) |-> pin_mode_o == scc_pkg::PIN_PORT &&
        !xtal_amp_en_o && int_osc_run_o)
        else $error("cpu started without internal clock only");
    reg_wait_a: assert property (
        poc_q == scc_pkg::POC_RESET_PROC &&
        $past(poc_q) == scc_pkg::POC_REG_WAIT
        |-> $past(poc_cnt_q) == PCNT_W'(REG_WAIT_CYC - 1))
        else $error("regulator wait has wrong length");
    fast_rise_a: assert property (
        poc_q == scc_pkg::POC_DUAL_WAIT && poc_low_ok_i && poc_high_ok_i &&
        poc_cnt_q < PCNT_W'(FAST_RISE_CYC) |=> poc_q == scc_pkg::POC_DELAY)
        else $error("fast rise did not insert delay");
    gain_once_a: assert property (
        gain_locked_q && !sys_rst |=> gain_q == $past(gain_q))
        else $error("gain changed twice");
    gain_hold_a: assert property (
        !sys_rst && !gain_q ##1 gain_q |=> !cpu_clk_en_o [*8])
        else $error("cpu clock not gated after gain set");
    stop_halt_a: assert property (
        stop_q |=> !int_osc_run_o && !xtal_amp_en_o)
        else $error("stop left a high clock running");
    stab_cap_a: assert property (
        stab_cnt_q <= limit)
        else $error("status counter passed selected time");
    restart_a: assert property (
        !xtal_on |=> stab_cnt_q == '0)
        else $error("status counter not restarted");
    ext_no_wait_a: assert property (
        xtal_on && xtal_on_q && pin_mode == scc_pkg::PIN_EXTCLK
        && !sys_rst |=> stab_done)
        else $error("external clock made to wait");
endmodule : scc_clock_ctrl

// ===== sim/scc_xtal_model.sv
`timescale 1ns/1ns
module scc_xtal_model #(
    parameter int HALF_CYC = 2
) (
    // system clock
    input wire logic clk_i,
    // drive request from the device
    input wire logic amp_en_i,
    input wire logic ext_sel_i,
    // clock seen at the pin
    output logic xtal_clk_o
);
    int cnt_q;
    // a stopped resonator leaves the pin quiet, never a stale phase
    always_ff @(posedge clk_i) begin
        if (!(amp_en_i || ext_sel_i)) begin
            cnt_q <= 0;
            xtal_clk_o <= 1'b0;
        end else if (cnt_q == HALF_CYC - 1) begin
            cnt_q <= 0;
            xtal_clk_o <= ~xtal_clk_o;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule : scc_xtal_model

// ===== sim/tb.sv
`timescale 1ns/1ns
module tb;
    localparam int FAST = 20;
    localparam int DLY = 60;
    localparam int REG = 10;
    logic clk_i, rstn_i, lo, hi, opt, stp, rel, on_hs, xclk, glk;
    scc_pkg::scc_req_s req;
    logic [7:0] rd_data_o, d;
    logic cpu_rst_n_o, cpu_clk_en_o, int_osc_run_o, xtal_amp_en_o;
    logic osc_high_gain_o;
    scc_pkg::scc_pin_e pin_mode_o;
    logic [7:0] mdl [4];
    logic [31:0] seed;
    int err_total, n_compared, edges, n;

    scc_clock_ctrl #(.FAST_RISE_CYC(FAST), .POC_DELAY_CYC(DLY),
        .REG_WAIT_CYC(REG)) scc_clock_ctrl_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .poc_low_ok_i(lo),
        .poc_high_ok_i(hi), .poc_threshold_option_i(opt),
        .stop_instr_i(stp), .stop_release_i(rel),
        .cpu_on_hs_clock_i(on_hs), .main_crystal_clock_i(xclk),
        .reg_req_i(req), .rd_data_o(rd_data_o),
        .cpu_rst_n_o(cpu_rst_n_o), .cpu_clk_en_o(cpu_clk_en_o),
        .int_osc_run_o(int_osc_run_o), .xtal_amp_en_o(xtal_amp_en_o),
        .osc_high_gain_o(osc_high_gain_o), .pin_mode_o(pin_mode_o));

    scc_xtal_model #(.HALF_CYC(2)) scc_xtal_model_i (
        .clk_i(clk_i), .amp_en_i(xtal_amp_en_o),
        .ext_sel_i(pin_mode_o == scc_pkg::PIN_EXTCLK),
        .xtal_clk_o(xclk));

    always @(posedge xclk) edges++;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cyc

    // register writes also update the reference copy of the map
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        logic b;
        @(posedge clk_i);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_i);
        req <= '0;
        #1;
        if (a == 4'h0) begin
            b = glk ? mdl[0][0] : v[0];
            glk = glk | (b != mdl[0][0]);
            mdl[0] = {v[7:6], 5'h00, b};
        end else if (a == 4'h1 && !(on_hs && v[7] && !mdl[1][7]))
            mdl[1] = {v[7], 7'h00};
        else if (a == 4'h3)
            mdl[3] = {5'h00, v[2:0]};
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_i);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        req <= '0;
        #1;
        v = rd_data_o;
    endtask : rd

    // status polled until the shortest step is reached
    task automatic poll();
        n = 0;
        d = 8'h00;
        while (d[0] !== 1'b1 && n < 6000) begin
            rd(4'h2, d);
            n++;
        end
        if (d[0] !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask : poll

    task automatic wait_clk_en();
        n = 0;
        while (cpu_clk_en_o !== 1'b1 && n < 20000) begin
            cyc(1);
            n++;
        end
        if (cpu_clk_en_o !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask : wait_clk_en

    task automatic power_up(input logic o, input int hi_at, input int lim);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        lo <= 1'b0;
        hi <= 1'b0;
        opt <= o;
        cyc(4);
        rstn_i <= 1'b1;
        cyc(1);
        chk(cpu_rst_n_o, 0);
        mdl = '{8'h00, 8'h80, 8'h00, 8'h05};
        glk = 1'b0;
        n = 0;
        while (cpu_rst_n_o !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            lo <= 1'b1;
            if (n == hi_at)
                hi <= 1'b1;
            n++;
            #1;
        end
        chk(n >= lim && n <= lim + 6, 1);
    endtask : power_up

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        #(40 * 100000);
        err_total++;
        close_out();
    end

    initial begin
        {rstn_i, lo, hi, opt, stp, rel, on_hs} = '0;
        req = '0;
        seed = 32'd26631;
        err_total = 0;
        n_compared = 0;
        edges = 0;
        power_up(1'b1, 5, DLY + 16);
        power_up(1'b1, FAST + 20, FAST + 36);
        power_up(1'b0, 2000, REG + 16);
        chk(int_osc_run_o, 1);
        chk({cpu_clk_en_o, xtal_amp_en_o}, 2'b10);
        chk(pin_mode_o, scc_pkg::PIN_PORT);
        repeat (4) wr(4'(4 + rnd() % 12), 8'(rnd()));
        for (int a = 0; a < 4; a++) begin
            rd(4'(a), d);
            chk(d, mdl[a]);
        end
        rd(4'hf, d);
        chk(d, 8'h00);
        wr(4'h0, 8'h01);
        n = 0;
        repeat (500) begin
            cyc(1);
            n += (cpu_clk_en_o === 1'b0);
        end
        chk(n >= scc_pkg::GAIN_HOLD_CYC && n <= 403, 1);
        chk(osc_high_gain_o, 1);
        wr(4'h0, 8'h00);
        rd(4'h0, d);
        chk({osc_high_gain_o, d}, {1'b1, mdl[0]});
        wr(4'h3, 8'h01);
        wr(4'h0, 8'h41);
        cyc(1);
        chk(pin_mode_o, scc_pkg::PIN_XTAL);
        wr(4'h1, 8'h00);
        edges = 0;
        cyc(2);
        chk(xtal_amp_en_o, 1);
        poll();
        chk(edges >= 2048 && cpu_clk_en_o === 1'b1, 1);
        // long enough that an uncapped count would reach the next step
        cyc(25000);
        rd(4'h2, d);
        chk(d, 8'h01);
        wr(4'h1, 8'h80);
        cyc(2);
        chk(xtal_amp_en_o, 0);
        wr(4'h1, 8'h00);
        rd(4'h2, d);
        chk(d, 8'h00);
        poll();
        on_hs <= 1'b1;
        wr(4'h1, 8'h80);
        rd(4'h1, d);
        chk(d, mdl[1]);
        @(posedge clk_i);
        stp <= 1'b1;
        @(posedge clk_i);
        stp <= 1'b0;
        cyc(2);
        chk({int_osc_run_o, cpu_clk_en_o, xtal_amp_en_o}, 0);
        @(posedge clk_i);
        rel <= 1'b1;
        edges = 0;
        @(posedge clk_i);
        rel <= 1'b0;
        wait_clk_en();
        chk(edges >= 2048, 1);
        on_hs <= 1'b0;
        wr(4'h1, 8'h80);
        wr(4'h0, 8'hc1);
        cyc(1);
        chk(pin_mode_o, scc_pkg::PIN_EXTCLK);
        wr(4'h1, 8'h00);
        cyc(4);
        rd(4'h2, d);
        chk({xtal_amp_en_o, d}, 9'h001);
        rd(4'h3, d);
        chk(d, mdl[3]);
        close_out();
    end
endmodule : tb
